/* File: rtl/sdi_reclock_pkg.sv */
// constants, offsets and types shared by the reclocker output control
package sdi_reclock_pkg;
  localparam int unsigned APB_AW = 8;
  localparam int unsigned RATE_W = 12;
  localparam logic [APB_AW-1:0] CTRL_OFFSET   = 8'h00;
  localparam logic [APB_AW-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [APB_AW-1:0] RATE_OFFSET   = 8'h08;
  localparam int unsigned CTRL_CLK_SEL_BIT   = 0;
  localparam int unsigned CTRL_SILENCE_N_BIT = 1;
  localparam int unsigned CTRL_BYPASS_BIT    = 2;
  localparam int unsigned CTRL_RATE_LSB      = 4;
  localparam logic        CLK_SEL_RESET      = 1'h0;
  localparam logic        SILENCE_N_RESET    = 1'h1;
  localparam logic        BYPASS_RESET       = 1'h0;
  localparam int unsigned STAT_LOCK_BIT      = 0;
  localparam int unsigned STAT_BYPASSED_BIT  = 1;
  localparam int unsigned STAT_PRIM_MUTE_BIT = 2;
  localparam int unsigned STAT_AUX_MUTE_BIT  = 3;
  localparam int unsigned STAT_RATE_OK_BIT   = 4;
  localparam int unsigned STAT_BUF_FULL_BIT  = 5;
  localparam logic [RATE_W-1:0] RATE_SD      = 12'h10E;
  localparam logic [RATE_W-1:0] RATE_HD_A    = 12'h5CB;
  localparam logic [RATE_W-1:0] RATE_HD_B    = 12'h5CD;
  localparam logic [RATE_W-1:0] RATE_3G_A    = 12'hB97;
  localparam logic [RATE_W-1:0] RATE_3G_B    = 12'hB9A;
  localparam int unsigned BIT_CYCLES_DEFAULT = 2;
  typedef enum logic [1:0] {
    RATE_AUTO,
    RATE_FORCE_SD,
    RATE_FORCE_HD,
    RATE_TEST
  } rate_sel_e;
endpackage

/* File: rtl/bit_stream_if.sv */
// valid/ready carrier for one serial bit between internal modules
`timescale 1ns/1ps
interface bit_stream_if;
  logic data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* File: rtl/two_entry_buffer.sv */
// two-entry bit buffer with registered ready toward the source
`timescale 1ns/1ps
module two_entry_buffer (
  input  wire logic   clk,
  input  wire logic   rst_n,
  bit_stream_if.snk   in_s,
  bit_stream_if.src   out_s
);
  logic [1:0] mem_r;
  logic [1:0] count_r;
  logic       ready_r;
  wire        push = in_s.valid & ready_r;
  wire        pop  = out_s.ready & (count_r != 2'h0);
  wire  [1:0] count_nxt = count_r + {1'b0, push} - {1'b0, pop};

  assign in_s.ready  = ready_r;
  assign out_s.valid = count_r != 2'h0;
  assign out_s.data  = mem_r[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_r   <= 2'h0;
      count_r <= 2'h0;
      ready_r <= 1'b1;
    end else begin
      if (pop)
        mem_r[0] <= (count_r == 2'h2) ? mem_r[1] : in_s.data;
      if (push && (count_r - {1'b0, pop}) == 2'h0)
        mem_r[0] <= in_s.data;
      if (push && (count_r - {1'b0, pop}) == 2'h1)
        mem_r[1] <= in_s.data;
      count_r <= count_nxt;
      ready_r <= count_nxt != 2'h2;
    end
  end
endmodule

/* File: rtl/bit_phase_divider.sv */
// divides pclk into bit intervals: start pulse and mid-interval clock level
`timescale 1ns/1ps
module bit_phase_divider #(
  parameter int unsigned BIT_CYCLES = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      bit_start,
  output logic      clk_high,
  output logic [7:0] phase
);
  localparam logic [7:0] LAST = 8'(BIT_CYCLES - 1);
  localparam logic [7:0] HALF = 8'(BIT_CYCLES / 2);
  logic [7:0] cnt_r;

  assign bit_start = cnt_r == 8'h00;
  assign clk_high  = cnt_r >= HALF;
  assign phase     = cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cnt_r <= 8'h00;
    else
      cnt_r <= (cnt_r == LAST) ? 8'h00 : cnt_r + 8'h01;
  end
endmodule

/* File: rtl/sdi_reclock_output_control.sv */
// output selection, muting, bypass and lock control of the serial reclocker
//
// Notes on behaviour
// [R01] clock select high: aux output carries recovered clock; low: retimed data copy.
// [R02] clock select resets low, so aux output defaults to second data copy.
// [R03] silence low mutes primary and aux outputs, whatever aux function.
// [R04] bypass with aux in clock mode mutes aux even when silence is high.
// [R05] muted outputs hold true and complement at fixed opposite levels.
// [R06] lock only at the five supported rates, never on harmonics.
// [R07] 143, 177, 360, 540 Mbps stay unlocked and pass through bypassed.
// [R08] aux clock rising edge sits at the centre of each bit interval.
// [R09] aux clock runs at one cycle per data bit.
// [R10] receivers treat aux clock as invalid when bypassed at unsupported rate.
// [R11] rate select: 00 auto, 01 force SD, 10 force HD and 3G.
// [R12] forced bypass passes data unretimed; otherwise bypass while unlocked.
// [R13] lock high only with data present and loop locked; low when forced bypass.
// [R14] silence overrides every bypass setting; it resets to outputs enabled.
`timescale 1ns/1ps
module sdi_reclock_output_control
  import sdi_reclock_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = sdi_reclock_pkg::BIT_CYCLES_DEFAULT
) (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic [sdi_reclock_pkg::APB_AW-1:0] paddr,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             serial_video_input,
  input  wire logic                             in_valid,
  output logic                                  in_ready,
  input  wire logic                             signal_present,
  input  wire logic                             loop_locked,
  input  wire logic [sdi_reclock_pkg::RATE_W-1:0] measured_rate,
  input  wire logic                             drive_ready,
  output logic                                  primary_serial_output_p,
  output logic                                  primary_serial_output_n,
  output logic                                  auxiliary_serial_output_p,
  output logic                                  auxiliary_serial_output_n,
  output logic                                  lock_indicator
);
  import sdi_reclock_pkg::*;

  bit_stream_if in_s ();
  bit_stream_if out_s ();

  // control register
  logic        clk_sel_r;
  logic        silence_n_r;
  logic        bypass_force_r;
  rate_sel_e   rate_sel_r;

  // apb answer
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  // line state
  logic        last_bit_r;
  logic        prim_p_r;
  logic        prim_n_r;
  logic        aux_p_r;
  logic        aux_n_r;
  logic        lock_r;
  logic        after_rst_r;

  logic        bit_start;
  logic        clk_high;
  logic [7:0]  phase;

  // apb decode
  wire         setup      = psel & ~penable;
  wire         access     = psel & penable & pready_r;
  wire         hit_ctrl   = paddr == CTRL_OFFSET;
  wire         hit_status = paddr == STATUS_OFFSET;
  wire         hit_rate   = paddr == RATE_OFFSET;
  wire         mapped     = hit_ctrl | hit_status | hit_rate;
  wire         ctrl_wr    = access & pwrite & hit_ctrl;

  // rate qualification
  wire         is_sd   = measured_rate == RATE_SD;
  wire         is_hd   = (measured_rate == RATE_HD_A) | (measured_rate == RATE_HD_B) |
                         (measured_rate == RATE_3G_A) | (measured_rate == RATE_3G_B);
  // exact match only: harmonics and the unsupported rates never qualify
  wire         rate_ok = (rate_sel_r == RATE_AUTO)     ? (is_sd | is_hd) :  // see [R06] [R07] [R11]
                         (rate_sel_r == RATE_FORCE_SD) ? is_sd :
                         (rate_sel_r == RATE_FORCE_HD) ? is_hd : 1'b0;

  // mode control
  wire         lock_nxt      = signal_present & loop_locked & rate_ok & ~bypass_force_r;  // see [R13]
  wire         bypass_active = bypass_force_r | ~lock_r;  // see [R12] [R07]
  wire         prim_mute     = ~silence_n_r;  // see [R03] [R14]
  // aux clock is meaningless while bypassed, so it is silenced too
  wire         aux_mute      = ~silence_n_r | (bypass_active & clk_sel_r);  // see [R04] [R10]

  // retimed data leaves once per bit interval; bypassed data leaves as it comes
  wire         drain    = out_s.valid & drive_ready & (bypass_active | bit_start);  // see [R12]
  wire         data_nxt = drain ? out_s.data : last_bit_r;
  wire         aux_sel  = clk_sel_r ? clk_high : data_nxt;  // see [R01] [R08] [R09]

  wire  [31:0] ctrl_word   = {26'h0, rate_sel_r, 1'b0, bypass_force_r, silence_n_r, clk_sel_r};
  wire  [31:0] status_word = {26'h0, ~in_s.ready, rate_ok, aux_mute, prim_mute,
                              bypass_active, lock_r};
  wire  [31:0] rate_word   = {20'h0, measured_rate};
  wire  [31:0] rd_mux      = hit_ctrl   ? ctrl_word :
                             hit_status ? status_word :
                             hit_rate   ? rate_word : 32'h0;

  assign in_s.data   = serial_video_input;
  assign in_s.valid  = in_valid;
  assign out_s.ready = drain;

  assign prdata                    = prdata_r;
  assign pready                    = pready_r;
  assign pslverr                   = pslverr_r;
  assign in_ready                  = in_s.ready;
  assign primary_serial_output_p   = prim_p_r;
  assign primary_serial_output_n   = prim_n_r;
  assign auxiliary_serial_output_p = aux_p_r;
  assign auxiliary_serial_output_n = aux_n_r;
  assign lock_indicator            = lock_r;

  two_entry_buffer u_buf (
    .clk   (pclk),
    .rst_n (presetn),
    .in_s  (in_s),
    .out_s (out_s)
  );

  bit_phase_divider #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_div (
    .clk       (pclk),
    .rst_n     (presetn),
    .bit_start (bit_start),
    .clk_high  (clk_high),
    .phase     (phase)
  );

  // apb slave
  // one wait-free access phase: answer is ready in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r  <= (setup & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel_r      <= CLK_SEL_RESET;  // see [R02]
      silence_n_r    <= SILENCE_N_RESET;  // see [R14]
      bypass_force_r <= BYPASS_RESET;
      rate_sel_r     <= RATE_AUTO;
    end else if (ctrl_wr) begin
      clk_sel_r      <= pwdata[CTRL_CLK_SEL_BIT];
      silence_n_r    <= pwdata[CTRL_SILENCE_N_BIT];
      bypass_force_r <= pwdata[CTRL_BYPASS_BIT];
      rate_sel_r     <= rate_sel_e'(pwdata[CTRL_RATE_LSB +: 2]);
    end
  end

  // line outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_bit_r <= 1'b0;
      lock_r     <= 1'b0;
      prim_p_r   <= 1'b0;
      prim_n_r   <= 1'b1;
      aux_p_r    <= 1'b0;
      aux_n_r    <= 1'b1;
    end else begin
      last_bit_r <= data_nxt;
      lock_r     <= lock_nxt;  // see [R06] [R13]
      // a muted pair parks at 0/1 instead of floating to a common level
      prim_p_r   <= prim_mute ? 1'b0 : data_nxt;  // see [R03] [R05]
      prim_n_r   <= prim_mute ? 1'b1 : ~data_nxt;
      aux_p_r    <= aux_mute ? 1'b0 : aux_sel;  // see [R01] [R04] [R05]
      aux_n_r    <= aux_mute ? 1'b1 : ~aux_sel;
    end
  end

  // checks
  localparam logic [7:0] HALF_PHASE = 8'(BIT_CYCLES / 2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      after_rst_r <= 1'b1;
    else
      after_rst_r <= 1'b0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_aux_data_copy;
    (silence_n_r && !clk_sel_r) |=> (aux_p_r == prim_p_r) && (aux_n_r == prim_n_r);
  endproperty
  a_aux_data_copy: assert property (p_aux_data_copy)  // see [R01]
    else $error("aux output does not copy primary data");

  property p_sel_default;
    after_rst_r |-> !clk_sel_r && silence_n_r;
  endproperty
  a_sel_default: assert property (p_sel_default)  // see [R02]
    else $error("control register left reset with wrong defaults");

  property p_silence_mutes;
    !silence_n_r |=> !prim_p_r && prim_n_r && !aux_p_r && aux_n_r;
  endproperty
  a_silence_mutes: assert property (p_silence_mutes)  // see [R03]
    else $error("silence did not mute both outputs");

  property p_bypass_clock_mute;
    (silence_n_r && bypass_active && clk_sel_r) |=> !aux_p_r && aux_n_r;
  endproperty
  a_bypass_clock_mute: assert property (p_bypass_clock_mute)  // see [R04]
    else $error("aux clock not muted during bypass");

  property p_pairs_opposite;
    (prim_p_r != prim_n_r) && (aux_p_r != aux_n_r);
  endproperty
  a_pairs_opposite: assert property (p_pairs_opposite)  // see [R05]
    else $error("differential legs at equal levels");

  property p_lock_cause;
    lock_r |-> $past(signal_present && loop_locked && rate_ok && !bypass_force_r);
  endproperty
  a_lock_cause: assert property (p_lock_cause)  // see [R06]
    else $error("lock raised without qualified rate");

  property p_unsupported_bypass;
    !rate_ok |=> !lock_r ##0 bypass_active;
  endproperty
  a_unsupported_bypass: assert property (p_unsupported_bypass)  // see [R07]
    else $error("unsupported rate did not force bypass");

  property p_clock_centre;
    (clk_sel_r && !aux_mute && $past(clk_sel_r && !aux_mute) && $rose(aux_p_r))
      |-> $past(phase) == HALF_PHASE;
  endproperty
  a_clock_centre: assert property (p_clock_centre)  // see [R08]
    else $error("aux clock edge off bit centre");

  property p_clock_rate;
    (clk_sel_r && !aux_mute && bit_start) |=> !aux_p_r;
  endproperty
  a_clock_rate: assert property (p_clock_rate)  // see [R09]
    else $error("aux clock not low at bit start");

  property p_force_bypass_drain;
    (bypass_force_r && out_s.valid && drive_ready) |-> out_s.ready;
  endproperty
  a_force_bypass_drain: assert property (p_force_bypass_drain)  // see [R12]
    else $error("forced bypass did not pass data at once");

  property p_force_bypass_unlock;
    bypass_force_r ##1 bypass_force_r |-> !lock_r;
  endproperty
  a_force_bypass_unlock: assert property (p_force_bypass_unlock)  // see [R13]
    else $error("lock high during forced bypass");

  property p_silence_over_bypass;
    (!silence_n_r && bypass_active) |=> !prim_p_r && prim_n_r && !aux_p_r && aux_n_r;
  endproperty
  a_silence_over_bypass: assert property (p_silence_over_bypass)  // see [R14]
    else $error("silence did not override bypass");

  property p_clock_follows_phase;
    (clk_sel_r && !aux_mute) |=> (aux_p_r == $past(clk_high)) && (aux_n_r != $past(clk_high));
  endproperty
  a_clock_follows_phase: assert property (p_clock_follows_phase)  // see [R01]
    else $error("aux output does not carry the bit clock");

  property p_reset_parked;
    after_rst_r |-> !prim_p_r && prim_n_r && !aux_p_r && aux_n_r && !lock_r;
  endproperty
  a_reset_parked: assert property (p_reset_parked)  // see [R05]
    else $error("outputs not parked after reset");

  property p_prim_follows_data;
    silence_n_r |=> (prim_p_r == $past(data_nxt)) && (prim_n_r != $past(data_nxt));
  endproperty
  a_prim_follows_data: assert property (p_prim_follows_data)  // see [R14]
    else $error("primary output not enabled while silence is high");

  property p_no_rate_no_lock;
    (!is_sd && !is_hd) |=> !lock_r;
  endproperty
  a_no_rate_no_lock: assert property (p_no_rate_no_lock)  // see [R06]
    else $error("lock raised on an unsupported rate");

  property p_forced_sd_only;
    (rate_sel_r == RATE_FORCE_SD && !is_sd) |=> !lock_r;
  endproperty
  a_forced_sd_only: assert property (p_forced_sd_only)  // see [R06]
    else $error("forced standard rate locked on another rate");

  property p_forced_hd_only;
    (rate_sel_r == RATE_FORCE_HD && !is_hd) |=> !lock_r;
  endproperty
  a_forced_hd_only: assert property (p_forced_hd_only)  // see [R06]
    else $error("forced high rate locked on another rate");

  property p_test_code_no_lock;
    (rate_sel_r == RATE_TEST) |=> !lock_r;
  endproperty
  a_test_code_no_lock: assert property (p_test_code_no_lock)  // see [R06]
    else $error("lock raised with test rate code");

  property p_no_signal_no_lock;
    (!signal_present || !loop_locked) |=> !lock_r;
  endproperty
  a_no_signal_no_lock: assert property (p_no_signal_no_lock)  // see [R13]
    else $error("lock raised without data or loop lock");

  property p_retimed_pacing;
    (!bypass_active && !bit_start) |-> !out_s.ready;
  endproperty
  a_retimed_pacing: assert property (p_retimed_pacing)  // see [R12]
    else $error("retimed bit left outside bit start");

  property p_auto_bypass_drain;
    (!lock_r && out_s.valid && drive_ready) |-> out_s.ready;
  endproperty
  a_auto_bypass_drain: assert property (p_auto_bypass_drain)  // see [R12]
    else $error("unlocked path did not pass data at once");

  property p_stall_holds;
    !drive_ready |-> !out_s.ready;
  endproperty
  a_stall_holds: assert property (p_stall_holds)  // see [R12]
    else $error("bit drained while downstream stalled");
endmodule

/* File: verif/line_driver_model.sv */
// downstream line driver model: stalls the drain and samples retimed bits
`timescale 1ns/1ps
module line_driver_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       stall,
  input  wire logic       mon_en,
  input  wire logic       lock_indicator,
  input  wire logic       prim_p,
  input  wire logic       aux_p,
  output logic            drive_ready,
  output logic            got_bit,
  output logic            got_val,
  output logic [7:0]      period
);
  logic [1:0] hist_r;
  logic       aux_prev_r;
  logic [7:0] cnt_r;
  wire        rise = aux_p && !aux_prev_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_ready <= 1'b1;
      hist_r <= 2'h0;
      aux_prev_r <= 1'b0;
      cnt_r <= 8'h00;
      got_bit <= 1'b0;
      got_val <= 1'b0;
      period <= 8'h00;
    end else begin
      drive_ready <= !stall;
      hist_r <= {hist_r[0], drive_ready};
      aux_prev_r <= aux_p;
      cnt_r <= rise ? 8'h00 : cnt_r + 8'h01;
      if (rise) begin
        period <= cnt_r + 8'h01;
      end
      // clock is only trusted while locked, a bit counts only if its drain edge saw ready
      got_bit <= mon_en && lock_indicator && rise && hist_r[1];
      got_val <= prim_p;
    end
  end
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the reclocker output control
`timescale 1ns/1ps
module tb_top;
  import sdi_reclock_pkg::*;
  localparam int unsigned BC = 2;
  localparam logic [32:0] MF = 33'h1FFFFFFFF;
  localparam logic [32:0] MS = 33'h100000003;
  localparam logic [RATE_W-1:0] RATES [11] = '{RATE_SD, RATE_HD_A, RATE_HD_B, RATE_3G_A, RATE_3G_B,
    12'h08F, 12'h0B1, 12'h168, 12'h21C, 12'h087, 12'hB96};
  localparam logic [1:0] FSEL [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  localparam logic [RATE_W-1:0] FRATE [5] = '{RATE_SD, RATE_HD_A, RATE_3G_B, RATE_SD, RATE_SD};
  localparam logic FLOCK [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rnd;
  logic              sin, in_valid, in_ready, sig_ok, locked, stall, hold, rnd_en;
  logic              feed, push_en, mon_en, drive_ready, pp, pn, ap, an, lock_ind, got_bit, got_val;
  logic [RATE_W-1:0] rate;
  logic [7:0]        period;
  logic [32:0]       exp_q [$];
  logic [32:0]       msk_q [$];
  logic              bit_q [$];
  int                mismatches, check_count, i;

  sdi_reclock_output_control #(.BIT_CYCLES(BC)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_video_input(sin),
    .in_valid(in_valid), .in_ready(in_ready), .signal_present(sig_ok), .loop_locked(locked),
    .measured_rate(rate), .drive_ready(drive_ready), .primary_serial_output_p(pp),
    .primary_serial_output_n(pn), .auxiliary_serial_output_p(ap), .auxiliary_serial_output_n(an),
    .lock_indicator(lock_ind));
  line_driver_model drv_u (
    .pclk(pclk), .presetn(presetn), .stall(stall), .mon_en(mon_en), .lock_indicator(lock_ind),
    .prim_p(pp), .aux_p(ap), .drive_ready(drive_ready), .got_bit(got_bit), .got_val(got_val),
    .period(period));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp_word(input logic [32:0] e, input logic [32:0] g, input logic [32:0] m);
    check_count++;
    if ((g & m) !== (e & m)) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, e & m, g & m);
    end
  endtask
  task automatic cmp_val(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // one APB transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask
  task automatic rd(input logic [APB_AW-1:0] a, input logic [32:0] e, input logic [32:0] m);
    apb(1'b0, a, 32'h0, e, m);
  endtask
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // result watcher: oldest note is taken whenever a result appears
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      cmp_word(exp_q.pop_front(), {pslverr, prdata}, msk_q.pop_front());
    if (got_bit === 1'b1 && bit_q.size() > 0) begin
      cmp_val({7'h0, bit_q.pop_front()}, {7'h0, got_val});
      cmp_val(8'(BC), period);
    end
  end
  // stream source and stall pattern; feeding faster than draining keeps the buffer full
  always @(posedge pclk) begin
    rnd <= lfsr(rnd);
    stall <= hold | (rnd_en & rnd[3] & rnd[9]);
    if (in_valid && in_ready && push_en) bit_q.push_back(sin);
    if (!in_valid || in_ready) begin
      in_valid <= feed;
      sin <= rnd[7];
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    stop_test();
  end
  initial begin
    {psel, penable, pwrite, presetn, sin, in_valid, sig_ok, locked} = '0;
    {stall, hold, rnd_en, feed, push_en, mon_en} = '0;
    paddr = '0;
    pwdata = 32'h0;
    rate = '0;
    rnd = 32'h6DDB;
    mismatches = 0;
    check_count = 0;
    repeat (4) @(posedge pclk);
    cmp_val({3'h0, lock_ind, pp, pn, ap, an}, 8'h05);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CTRL_OFFSET, 33'h2, 33'h10000003F);
    rd(8'h0C, 33'h100000000, MF);
    sig_ok <= 1'b1;
    locked <= 1'b1;
    feed <= 1'b1;
    for (i = 0; i < 11; i++) begin
      rate <= RATES[i];
      settle();
      rd(STATUS_OFFSET, {31'h0, i >= 5, i < 5}, MS);
      cmp_val({7'h0, i < 5}, {7'h0, lock_ind});
    end
    rate <= RATE_SD;
    sig_ok <= 1'b0;
    settle();
    cmp_val(8'h00, {7'h0, lock_ind});
    sig_ok <= 1'b1;
    for (i = 0; i < 5; i++) begin
      wr(CTRL_OFFSET, {26'h0, FSEL[i], 4'h2});
      rate <= FRATE[i];
      settle();
      cmp_val({7'h0, FLOCK[i]}, {7'h0, lock_ind});
    end
    wr(CTRL_OFFSET, 32'h6);
    rate <= RATE_SD;
    settle();
    rd(STATUS_OFFSET, 33'h2, MS);
    wr(CTRL_OFFSET, 32'h4);
    rd(STATUS_OFFSET, 33'hC, 33'hC);
    cmp_val({4'h0, pp, pn, ap, an}, 8'h05);
    wr(CTRL_OFFSET, 32'h5);
    cmp_val({4'h0, pp, pn, ap, an}, 8'h05);
    wr(CTRL_OFFSET, 32'h7);
    rd(STATUS_OFFSET, 33'h8, 33'hC);
    for (i = 0; i < 6; i++) @(posedge pclk) cmp_val({6'h0, ap, an}, 8'h01);
    wr(CTRL_OFFSET, 32'h3);
    rate <= 12'h08F;
    settle();
    cmp_val({6'h0, ap, an}, 8'h01);
    feed <= 1'b0;
    repeat (10) @(posedge pclk);
    hold <= 1'b1;
    rate <= RATE_HD_A;
    settle();
    rd(RATE_OFFSET, {21'h0, RATE_HD_A}, MF);
    push_en <= 1'b1;
    feed <= 1'b1;
    for (i = 0; i < 50 && in_ready !== 1'b0; i++) @(posedge pclk);
    rd(STATUS_OFFSET, 33'h21, 33'h23);
    cmp_val(8'h00, {7'h0, in_ready});
    mon_en <= 1'b1;
    hold <= 1'b0;
    rnd_en <= 1'b1;
    repeat (300) @(posedge pclk);
    mon_en <= 1'b0;
    rnd_en <= 1'b0;
    settle();
    push_en <= 1'b0;
    bit_q.delete();
    wr(CTRL_OFFSET, 32'h2);
    for (i = 0; i < 8; i++) @(posedge pclk) cmp_val({6'h0, ap, an}, {6'h0, pp, pn});
    stop_test();
  end
endmodule
